//--- design/eee_port_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - The data byte register at 0xa0 returns and accepts the addressed byte.
// - Ability register upper byte sits at offset 0x28, lower byte at 0x29.
// - Bits 14 to 9 report partner EEE support per line type, reset zero.
// - Bit 1 is a writable local 100BASE-TX EEE flag, reset one.
// - Bits 15, 8 to 2 and 0 are reserved, read as zero.
// - Wakeup error counter adds one per wakeup longer than the threshold.
// - Threshold comes from a global register, default 20.5 microseconds.
// - Reading the counter returns it and clears it; reset value zero.
module eee_port_regs
   import eee_pkg::*;
(
   input  wire logic                          i_clk,
   input  wire logic                          i_sys_rst,
   input  wire logic [7:0]                    i_addr,
   input  wire logic                          i_wr,
   input  wire logic                          i_rd,
   input  wire logic [7:0]                    i_wdata,
   input  wire logic [NUM_PORTS*LP_ABIL_W-1:0] i_lp_eee_ability,
   input  wire logic [NUM_PORTS-1:0]          i_wake_busy,
   input  wire logic [15:0]                   i_wake_thr,
   output var  logic [7:0]                    o_rdata,
   output var  logic                          o_rvalid,
   output var  logic [NUM_PORTS-1:0]          o_local_100tx_eee
);
   logic [7:0]           ind_ctrl;
   logic [7:0]           ind_offs;
   logic                 sel_ok;
   logic                 data_rd;
   logic                 data_wr;
   logic [NUM_PORTS-1:0] port_hit;
   logic [NUM_PORTS-1:0] wake_err;
   logic [NUM_PORTS-1:0] werr_clr;
   logic [15:0]          werr [NUM_PORTS];
   logic [7:0]           werr_snap [NUM_PORTS];
   logic [LP_ABIL_W-1:0] lp_sel;
   logic                 local_sel;
   logic [15:0]          werr_sel;
   logic [7:0]           snap_sel;
   logic [7:0]           next_rdata;

   // Indirect control and offset registers.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ind_ctrl <= CTRL_RST;
      end else if (i_wr && i_addr == ADDR_IND_CTRL) begin
         ind_ctrl <= i_wdata;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ind_offs <= OFFS_RST;
      end else if (i_wr && i_addr == ADDR_IND_OFFS) begin
         ind_offs <= i_wdata;
      end
   end

   assign sel_ok  = ind_ctrl[TBL_SEL_MSB:TBL_SEL_LSB] == TBL_EEE
                    && ind_ctrl[PORT_SEL_MSB:0] >= PORT_MIN
                    && ind_ctrl[PORT_SEL_MSB:0] <= PORT_MAX;
   assign data_rd = i_rd && i_addr == ADDR_IND_DATA && sel_ok;
   assign data_wr = i_wr && i_addr == ADDR_IND_DATA && sel_ok;

   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_port
         localparam logic [3:0] PNUM = 4'(p + 1);

         assign port_hit[p] = ind_ctrl[PORT_SEL_MSB:0] == PNUM;
         assign werr_clr[p] = data_rd && port_hit[p] && ind_offs == OFS_WERR_HI;

         eee_wake_timer u_timer (
            .i_clk       (i_clk),
            .i_sys_rst   (i_sys_rst),
            .i_wake_busy (i_wake_busy[p]),
            .i_wake_thr  (i_wake_thr),
            .o_wake_err  (wake_err[p])
         );

         always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               o_local_100tx_eee[p] <= LOCAL_RST;
            end else if (data_wr && port_hit[p] && ind_offs == OFS_ABIL_LO) begin
               o_local_100tx_eee[p] <= i_wdata[LOCAL_BIT];
            end
         end

         // A wakeup error in the clearing cycle survives as a count of one.
         always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               werr[p] <= WERR_RST;
            end else if (werr_clr[p]) begin
               werr[p] <= wake_err[p] ? 16'h0001 : WERR_RST;
            end else if (wake_err[p] && werr[p] != WERR_MAX) begin
               werr[p] <= werr[p] + 16'h0001;
            end
         end

         // The low byte is captured when the high byte is read and cleared.
         always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               werr_snap[p] <= RDATA_RST;
            end else if (werr_clr[p]) begin
               werr_snap[p] <= werr[p][7:0];
            end
         end

         werr_inc_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
            wake_err[p] && !werr_clr[p] && werr[p] != WERR_MAX
            |=> werr[p] == $past(werr[p]) + 16'h0001)
            else $error("Wakeup error count did not advance.");
         werr_clr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
            werr_clr[p] |=> werr[p] == {15'h0000, $past(wake_err[p])}
                            && werr_snap[p] == $past(werr[p][7:0]))
            else $error("Wakeup error count not cleared by read.");
         werr_sat_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
            werr[p] == WERR_MAX && !werr_clr[p] |=> werr[p] == WERR_MAX)
            else $error("Wakeup error count wrapped.");
         local_wr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
            data_wr && port_hit[p] && ind_offs == OFS_ABIL_LO
            |=> o_local_100tx_eee[p] == $past(i_wdata[LOCAL_BIT]))
            else $error("Local capability flag not written.");
         local_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
            !(data_wr && port_hit[p] && ind_offs == OFS_ABIL_LO)
            |=> $stable(o_local_100tx_eee[p]))
            else $error("Local capability flag changed without a write.");
         werr_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
            !wake_err[p] && !werr_clr[p] |=> $stable(werr[p]))
            else $error("Wakeup error count changed without an event.");
         snap_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
            !werr_clr[p] |=> $stable(werr_snap[p]))
            else $error("Captured low byte changed without a read.");
      end
   endgenerate

   // Per-port values seen through the current port selection.
   always_comb begin
      lp_sel    = '0;
      local_sel = 1'b0;
      werr_sel  = WERR_RST;
      snap_sel  = RDATA_RST;
      for (int i = 0; i < NUM_PORTS; i++) begin
         if (port_hit[i]) begin
            lp_sel    = i_lp_eee_ability[i*LP_ABIL_W +: LP_ABIL_W];
            local_sel = o_local_100tx_eee[i];
            werr_sel  = werr[i];
            snap_sel  = werr_snap[i];
         end
      end
   end

   // Byte returned for a read; unselected windows and offsets read zero.
   always_comb begin
      next_rdata = RDATA_RST;
      if (i_addr == ADDR_IND_CTRL) begin
         next_rdata = ind_ctrl;
      end else if (i_addr == ADDR_IND_OFFS) begin
         next_rdata = ind_offs;
      end else if (i_addr == ADDR_IND_DATA && sel_ok) begin
         unique case (ind_offs)
            OFS_ABIL_HI: next_rdata = {1'b0, lp_sel, 1'b0};
            OFS_ABIL_LO: next_rdata = {6'h00, local_sel, 1'b0};
            OFS_WERR_HI: next_rdata = werr_sel[15:8];
            OFS_WERR_LO: next_rdata = snap_sel;
            default:     next_rdata = RDATA_RST;
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rdata <= RDATA_RST;
      end else if (i_rd) begin
         o_rdata <= next_rdata;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rvalid <= 1'b0;
      end else begin
         o_rvalid <= i_rd;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   abil_hi_rd_a: assert property (data_rd && ind_offs == OFS_ABIL_HI
      |=> o_rdata == {1'b0, $past(lp_sel), 1'b0} && o_rvalid)
      else $error("Partner ability byte wrong.");
   abil_lo_rd_a: assert property (data_rd && ind_offs == OFS_ABIL_LO
      |=> o_rdata[7:2] == 6'h00 && !o_rdata[0] && o_rdata[1] == $past(local_sel))
      else $error("Ability low byte wrong.");
   werr_hi_rd_a: assert property (data_rd && ind_offs == OFS_WERR_HI
      |=> o_rdata == $past(werr_sel[15:8]))
      else $error("Wakeup count high byte wrong.");
   unsel_rd_a: assert property (i_rd && i_addr == ADDR_IND_DATA && !sel_ok
      |=> o_rdata == RDATA_RST)
      else $error("Unselected window did not read zero.");
   werr_lo_rd_a: assert property (data_rd && ind_offs == OFS_WERR_LO
      |=> o_rdata == $past(snap_sel) && o_rvalid)
      else $error("Wakeup count low byte wrong.");
   rvalid_a: assert property (o_rvalid == $past(i_rd))
      else $error("Read valid not one cycle after read.");
   rdata_hold_a: assert property (!i_rd |=> $stable(o_rdata))
      else $error("Read data changed without a read.");
   unmap_rd_a: assert property (i_rd && i_addr != ADDR_IND_CTRL
      && i_addr != ADDR_IND_OFFS && i_addr != ADDR_IND_DATA
      |=> o_rdata == RDATA_RST)
      else $error("Unmapped address did not read zero.");
   ctrl_wr_a: assert property (i_wr && i_addr == ADDR_IND_CTRL
      |=> ind_ctrl == $past(i_wdata))
      else $error("Control register not written.");
   offs_wr_a: assert property (i_wr && i_addr == ADDR_IND_OFFS
      |=> ind_offs == $past(i_wdata))
      else $error("Offset register not written.");
endmodule
`default_nettype wire

//--- design/eee_pkg.sv
package eee_pkg;
   localparam int          NUM_PORTS       = 3;
   localparam logic [7:0]  ADDR_IND_CTRL   = 8'h6e;
   localparam logic [7:0]  ADDR_IND_OFFS   = 8'h6f;
   localparam logic [7:0]  ADDR_IND_DATA   = 8'ha0;
   localparam int          PORT_SEL_MSB    = 3;
   localparam int          TBL_SEL_MSB     = 7;
   localparam int          TBL_SEL_LSB     = 5;
   localparam logic [2:0]  TBL_EEE         = 3'h1;
   localparam logic [3:0]  PORT_MIN        = 4'h1;
   localparam logic [3:0]  PORT_MAX        = 4'h3;
   localparam logic [7:0]  CTRL_RST        = 8'h00;
   localparam logic [7:0]  OFFS_RST        = 8'h00;
   localparam logic [7:0]  OFS_ABIL_HI     = 8'h28;
   localparam logic [7:0]  OFS_ABIL_LO     = 8'h29;
   localparam logic [7:0]  OFS_WERR_HI     = 8'h2a;
   localparam logic [7:0]  OFS_WERR_LO     = 8'h2b;
   localparam int          LP_ABIL_W       = 6;
   localparam int          LOCAL_BIT       = 1;
   localparam logic        LOCAL_RST       = 1'b1;
   localparam logic [15:0] WERR_RST        = 16'h0000;
   localparam logic [15:0] WERR_MAX        = 16'hffff;
   localparam logic [7:0]  RDATA_RST       = 8'h00;
   localparam int          CLK_PERIOD_PS   = 10000;
   localparam int          WAKE_THR_PS     = 20500000;
   localparam logic [15:0] WAKE_THR_DEF    = 16'(WAKE_THR_PS / CLK_PERIOD_PS);
endpackage

//--- design/eee_wake_timer.sv
`timescale 1ns/1ps
`default_nettype none
module eee_wake_timer
   import eee_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_wake_busy,
   input  wire logic [15:0] i_wake_thr,
   output var  logic        o_wake_err
);
   logic        busy_q;
   logic [15:0] wcnt;

   // Counts the cycles of one wakeup and saturates on very long ones.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wcnt <= WERR_RST;
      end else if (!i_wake_busy) begin
         wcnt <= WERR_RST;
      end else if (wcnt != WERR_MAX) begin
         wcnt <= wcnt + 16'h0001;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= i_wake_busy;
      end
   end

   // Flags a wakeup whose length passed the threshold when it ends.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_wake_err <= 1'b0;
      end else begin
         o_wake_err <= !i_wake_busy && busy_q && (wcnt > i_wake_thr);
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   wake_long_a: assert property (!i_wake_busy && busy_q && wcnt > i_wake_thr |=> o_wake_err)
      else $error("Long wakeup not flagged.");
   wake_short_a: assert property (o_wake_err |-> $past(wcnt) > $past(i_wake_thr))
      else $error("Short wakeup flagged.");
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module testbench;
   import eee_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic [7:0]  i_addr = 8'h00;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [7:0]  i_wdata = 8'h00;
   logic [17:0] lp = 18'h00000;
   logic [2:0]  busy = 3'h0;
   logic [15:0] thr = 16'h0005;
   logic [7:0]  o_rdata;
   logic        o_rvalid;
   logic [2:0]  o_local;
   int          n_fail = 0;
   int          checks = 0;
   eee_port_regs u_eee_port_regs (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
      .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .i_lp_eee_ability(lp),
      .i_wake_busy(busy), .i_wake_thr(thr), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
      .o_local_100tx_eee(o_local));
   always #5 i_clk = ~i_clk;
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      i_addr = a;
      i_wdata = d;
      i_wr = 1'b1;
      @(negedge i_clk);
      i_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      @(negedge i_clk);
      i_addr = a;
      i_rd = 1'b1;
      @(negedge i_clk);
      i_rd = 1'b0;
      `CHK("rvalid", 1'b1, o_rvalid)
      `CHK(nm, e, o_rdata)
   endtask
   task automatic sel(input logic [3:0] p, input logic [7:0] ofs);
      wr(ADDR_IND_CTRL, {TBL_EEE, 1'b0, p});
      wr(ADDR_IND_OFFS, ofs);
   endtask
   task automatic acc(input logic [3:0] p, input logic [7:0] ofs, input logic [7:0] e,
                      input string nm);
      sel(p, ofs);
      rd(ADDR_IND_DATA, e, nm);
   endtask
   task automatic pulse(input int p, input int n);
      @(negedge i_clk);
      busy[p] = 1'b1;
      repeat (n) @(negedge i_clk);
      busy[p] = 1'b0;
      repeat (4) @(negedge i_clk);
   endtask
   task automatic t_reset();
      `CHK("local flags", 3'b111, o_local)
      for (int p = 1; p <= 3; p++) begin
         acc(4'(p), OFS_ABIL_HI, 8'h00, "ability hi");
         acc(4'(p), OFS_ABIL_LO, 8'h02, "ability lo");
         acc(4'(p), OFS_WERR_HI, 8'h00, "count hi");
      end
      $display("test reset done");
   endtask
   task automatic t_partner();
      logic [5:0] v [3];
      v = '{6'h3f, 6'h15, 6'h2a};
      lp = {v[2], v[1], v[0]};
      for (int p = 1; p <= 3; p++) begin
         acc(4'(p), OFS_ABIL_HI, {1'b0, v[p-1], 1'b0}, "partner bits");
      end
      lp = 18'h00001;
      acc(4'h1, OFS_ABIL_HI, 8'h02, "partner tx bit");
      $display("test partner done");
   endtask
   task automatic t_local();
      sel(4'h2, OFS_ABIL_LO);
      wr(ADDR_IND_DATA, 8'hff);
      rd(ADDR_IND_DATA, 8'h02, "reserved kept");
      wr(ADDR_IND_DATA, 8'h00);
      rd(ADDR_IND_DATA, 8'h00, "local cleared");
      `CHK("local flags", 3'b101, o_local)
      wr(ADDR_IND_CTRL, 8'h42);
      wr(ADDR_IND_DATA, 8'h02);
      rd(ADDR_IND_DATA, 8'h00, "other table");
      acc(4'h2, OFS_ABIL_LO, 8'h00, "write refused");
      acc(4'h0, OFS_ABIL_LO, 8'h00, "port zero");
      acc(4'h3, 8'h27, 8'h00, "offset miss");
      rd(8'h55, 8'h00, "unmapped");
      acc(4'h1, OFS_ABIL_LO, 8'h02, "port one kept");
      $display("test local done");
   endtask
   task automatic t_wake();
      pulse(0, 5);
      pulse(0, 6);
      pulse(0, 9);
      pulse(1, 6);
      acc(4'h1, OFS_WERR_HI, 8'h00, "count hi");
      acc(4'h1, OFS_WERR_LO, 8'h02, "count lo");
      acc(4'h1, OFS_WERR_HI, 8'h00, "cleared hi");
      acc(4'h1, OFS_WERR_LO, 8'h00, "cleared lo");
      acc(4'h2, OFS_WERR_HI, 8'h00, "port two hi");
      acc(4'h2, OFS_WERR_LO, 8'h01, "port two lo");
      thr = WAKE_THR_DEF;
      pulse(2, 2050);
      pulse(2, 2051);
      acc(4'h3, OFS_WERR_HI, 8'h00, "default hi");
      acc(4'h3, OFS_WERR_LO, 8'h01, "default lo");
      $display("test wake done");
   endtask
   initial begin
      repeat (20) @(negedge i_clk);
      i_sys_rst = 1'b0;
      t_reset();
      t_partner();
      t_local();
      t_wake();
      conclude();
   end
   initial begin
      #500us;
      n_fail++;
      conclude();
   end
endmodule
`default_nettype wire
